//--- include/lpirq_consts.svh
// register offsets, field positions, reset values and times in nanoseconds
`ifndef LPIRQ_CONSTS_SVH
`define LPIRQ_CONSTS_SVH

// register indexes; byte address is four times the index
`define LPIRQ_IDX_ENABLE 8'hC6
`define LPIRQ_IDX_STATUS 8'hC7
`define LPIRQ_IDX_CHECK 8'hC8
`define LPIRQ_IDX_OPTION 8'hCA
`define LPIRQ_IDX_BLUE 8'hCE
`define LPIRQ_IDX_REMOTE 8'hD0

`define LPIRQ_RST_ENABLE 8'h00
`define LPIRQ_RST_BLUE 8'hFF

// field positions
`define LPIRQ_B_GLOBAL 0
`define LPIRQ_B_CHK_OK 7
`define LPIRQ_B_CHK_FIN 6
`define LPIRQ_B_CHK_GO 2
`define LPIRQ_B_RM_RESET 7
`define LPIRQ_B_RM_SHORT 6
`define LPIRQ_B_RM_OFF 5
`define LPIRQ_B_RM_FAST 4
`define LPIRQ_B_RM_ACKED 1
`define LPIRQ_B_RM_DONE 0

// timing
`define LPIRQ_CLK_NS 10
`define LPIRQ_IDLE_LONG_NS 1000000000
`define LPIRQ_IDLE_SHORT_NS 50000

// key store walked by the check
`define LPIRQ_KEY_LAST 6'h27

`endif

//--- include/lpirq_pkg.sv
// types shared by the protection register bank
package lpirq_pkg;
	typedef enum logic [1:0] {
		CHK_IDLE = 2'b00,
		CHK_READ = 2'b01,
		CHK_FEED = 2'b10,
		CHK_WAIT = 2'b11
	} lpirq_chk_t;
endpackage: lpirq_pkg

//--- verilog/lpirq_regs.sv
// interrupt, key-store check, blue fill and remote access register bank
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "lpirq_consts.svh"
module lpirq_regs #(
	parameter int unsigned IDLE_LONG_CYC = `LPIRQ_IDLE_LONG_NS / `LPIRQ_CLK_NS,
	parameter int unsigned IDLE_SHORT_CYC = `LPIRQ_IDLE_SHORT_NS / `LPIRQ_CLK_NS
) (
	input wire logic REF_CLK, // core clock
	input wire logic RESET, // synchronous reset
	input wire logic CLK_EN, // freezes all state while low
	input wire logic [9:0] WB_ADR_I, // byte address
	input wire logic [31:0] WB_DAT_I, // write data
	output logic [31:0] WB_DAT_O, // read data
	input wire logic [3:0] WB_SEL_I, // byte enables
	input wire logic WB_WE_I, // write
	input wire logic WB_CYC_I, // cycle
	input wire logic WB_STB_I, // strobe
	output logic WB_ACK_O, // acknowledge
	output logic INT_OUT, // interrupt to controller
	input wire logic HANDSHAKE_PASS, // pulse
	input wire logic HANDSHAKE_FAIL, // pulse
	input wire logic SINK_KEY_READY, // pulse
	input wire logic KEY_LIST_READY, // pulse
	input wire logic DOWNSTREAM_REQUEST_N, // level, low requests
	input wire logic SINK_FOUND, // level
	input wire logic SINK_LOCKED, // level
	input wire logic REMOTE_START, // pulse, access begins
	input wire logic REMOTE_DONE, // pulse, access ends
	input wire logic REMOTE_TARGET_ACKED, // with done
	input wire logic REMOTE_BUS_ACTIVE, // signalling seen
	output logic REMOTE_MASTER_RESET, // pulse
	output logic REMOTE_FAST_MODE, // level
	output logic REMOTE_IDLE_TIMEOUT, // bus deemed free
	output logic [5:0] KEY_ADDR, // key store address
	input wire logic [31:0] KEY_DATA, // one cycle after address
	output logic HASH_START, // pulse
	output logic [31:0] HASH_WORD, // word to hash
	output logic HASH_WORD_VALID, // pulse
	input wire logic HASH_DONE, // pulse with digest
	input wire logic [159:0] HASH_DIGEST, // computed digest
	input wire logic [159:0] STORED_DIGEST, // digest held in store
	input wire logic BLUE_SUBSTITUTE, // blue screen active
	input wire logic [7:0] VIDEO_BLUE, // normal blue channel
	output logic [7:0] BLUE_OUT // blue channel out
);

	// ************************************************
	// bus decode
	// ************************************************
	logic ack;
	logic [31:0] dat_o;
	logic [7:0] enable;
	logic [7:1] status;
	logic chk_ok;
	logic chk_fin;
	logic chk_go;
	logic [2:0] chk_spare;
	logic needs_lock;
	logic [7:0] blue;
	logic rm_short;
	logic rm_off;
	logic rm_fast;
	logic rm_acked;
	logic rm_done;
	logic rm_reset;
	logic found_q;
	logic req_n_q;
	logic [31:0] idle_cnt;
	lpirq_pkg::lpirq_chk_t chk_state;

	wire req = WB_CYC_I & WB_STB_I & ~ack;
	wire [7:0] idx = WB_ADR_I[9:2];
	wire wr = req & WB_WE_I & WB_SEL_I[0];
	wire rd = req & ~WB_WE_I;
	wire [7:0] wd = WB_DAT_I[7:0];
	wire wr_enable = wr & (idx == `LPIRQ_IDX_ENABLE);
	wire wr_status = wr & (idx == `LPIRQ_IDX_STATUS);
	wire wr_check = wr & (idx == `LPIRQ_IDX_CHECK);
	wire wr_option = wr & (idx == `LPIRQ_IDX_OPTION);
	wire wr_blue = wr & (idx == `LPIRQ_IDX_BLUE);
	wire wr_remote = wr & (idx == `LPIRQ_IDX_REMOTE);
	wire rd_remote = rd & (idx == `LPIRQ_IDX_REMOTE);

	// ************************************************
	// interrupt events
	// ************************************************
	wire found_cond = SINK_FOUND & (~needs_lock | SINK_LOCKED);
	wire [7:1] ev;
	assign ev[7] = REMOTE_DONE;
	assign ev[6] = found_cond & ~found_q;
	assign ev[5] = req_n_q & ~DOWNSTREAM_REQUEST_N;
	assign ev[4] = KEY_LIST_READY;
	assign ev[3] = SINK_KEY_READY;
	assign ev[2] = HANDSHAKE_FAIL;
	assign ev[1] = HANDSHAKE_PASS;
	wire [7:1] st_clr = wr_status ? wd[7:1] : 7'h00;
	// set wins so an event in the clearing cycle survives
	wire [7:1] next_status = (status & ~st_clr) | ev;
	wire global_int = |(status & enable[7:1]);
	assign INT_OUT = enable[`LPIRQ_B_GLOBAL] & global_int;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			status <= 7'h00;
			found_q <= 1'b0;
			req_n_q <= 1'b1;
		end else if (CLK_EN) begin
			status <= next_status;
			found_q <= found_cond;
			req_n_q <= DOWNSTREAM_REQUEST_N;
		end
	end

	// ************************************************
	// software written registers
	// ************************************************
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			enable <= `LPIRQ_RST_ENABLE;
			blue <= `LPIRQ_RST_BLUE;
			needs_lock <= 1'b0;
			chk_spare <= 3'h0;
		end else if (CLK_EN) begin
			if (wr_enable)
				enable <= wd;
			if (wr_blue)
				blue <= wd;
			if (wr_option)
				needs_lock <= wd[0];
			if (wr_check)
				chk_spare <= {wd[5], wd[1:0]};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rm_short <= 1'b0;
			rm_off <= 1'b0;
			rm_fast <= 1'b0;
			rm_reset <= 1'b0;
		end else if (CLK_EN) begin
			rm_reset <= wr_remote & wd[`LPIRQ_B_RM_RESET];
			if (wr_remote) begin
				rm_short <= wd[`LPIRQ_B_RM_SHORT];
				rm_off <= wd[`LPIRQ_B_RM_OFF];
				rm_fast <= wd[`LPIRQ_B_RM_FAST];
			end
		end
	end

	assign REMOTE_MASTER_RESET = rm_reset;
	assign REMOTE_FAST_MODE = rm_fast;

	// ************************************************
	// remote access status
	// ************************************************
	// a done in the same cycle as the read keeps the flag
	wire next_rm_done = REMOTE_DONE | (rm_done & ~rd_remote & ~REMOTE_START);

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			rm_done <= 1'b0;
			rm_acked <= 1'b0;
		end else if (CLK_EN) begin
			rm_done <= next_rm_done;
			if (REMOTE_DONE)
				rm_acked <= REMOTE_TARGET_ACKED;
			else if (REMOTE_START)
				rm_acked <= 1'b0;
		end
	end

	// ************************************************
	// remote bus idle timer
	// ************************************************
	wire [31:0] idle_limit = rm_short ? IDLE_SHORT_CYC : IDLE_LONG_CYC;
	// counter saturates just past the limit so it never wraps
	wire idle_over = idle_cnt > idle_limit;

	always_ff @(posedge REF_CLK) begin
		if (RESET)
			idle_cnt <= 32'h0000_0000;
		else if (CLK_EN) begin
			if (REMOTE_BUS_ACTIVE | rm_reset)
				idle_cnt <= 32'h0000_0000;
			else if (!idle_over)
				idle_cnt <= idle_cnt + 32'h0000_0001;
		end
	end

	assign REMOTE_IDLE_TIMEOUT = ~rm_off & idle_over;

	// ************************************************
	// key store check
	// ************************************************
	wire chk_start = wr_check & wd[`LPIRQ_B_CHK_GO] & (chk_state == lpirq_pkg::CHK_IDLE);
	wire digest_match = HASH_DIGEST == STORED_DIGEST;

	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			chk_state <= lpirq_pkg::CHK_IDLE;
			chk_go <= 1'b0;
			chk_fin <= 1'b0;
			chk_ok <= 1'b0;
			KEY_ADDR <= 6'h00;
			HASH_START <= 1'b0;
			HASH_WORD <= 32'h0000_0000;
			HASH_WORD_VALID <= 1'b0;
		end else if (CLK_EN) begin
			HASH_START <= chk_start;
			HASH_WORD_VALID <= chk_state == lpirq_pkg::CHK_FEED;
			case (chk_state)
				lpirq_pkg::CHK_IDLE: begin
					if (chk_start) begin
						chk_go <= 1'b1;
						chk_fin <= 1'b0;
						chk_ok <= 1'b0;
						KEY_ADDR <= 6'h00;
						chk_state <= lpirq_pkg::CHK_READ;
					end
				end
				lpirq_pkg::CHK_READ: begin
					chk_state <= lpirq_pkg::CHK_FEED;
				end
				lpirq_pkg::CHK_FEED: begin
					HASH_WORD <= KEY_DATA;
					if (KEY_ADDR == `LPIRQ_KEY_LAST)
						chk_state <= lpirq_pkg::CHK_WAIT;
					else begin
						KEY_ADDR <= KEY_ADDR + 6'h01;
						chk_state <= lpirq_pkg::CHK_READ;
					end
				end
				lpirq_pkg::CHK_WAIT: begin
					if (HASH_DONE) begin
						chk_ok <= digest_match;
						chk_fin <= 1'b1;
						chk_go <= 1'b0;
						chk_state <= lpirq_pkg::CHK_IDLE;
					end
				end
				default: begin
					chk_state <= lpirq_pkg::CHK_IDLE;
				end
			endcase
		end
	end

	// ************************************************
	// blue fill
	// ************************************************
	always_ff @(posedge REF_CLK) begin
		if (RESET)
			BLUE_OUT <= 8'h00;
		else if (CLK_EN)
			BLUE_OUT <= BLUE_SUBSTITUTE ? blue : VIDEO_BLUE;
	end

	// ************************************************
	// read mux and acknowledge
	// ************************************************
	wire [7:0] rd_status_v = {status, global_int};
	wire [7:0] rd_check_v = {chk_ok, chk_fin, chk_spare[2], 2'b00, chk_go, chk_spare[1:0]};
	wire [7:0] rd_remote_v = {1'b0, rm_short, rm_off, rm_fast, 2'b00, rm_acked, rm_done};
	wire [7:0] rd_option_v = {7'h00, needs_lock};
	wire [7:0] rd_byte =
		(idx == `LPIRQ_IDX_ENABLE) ? enable :
		(idx == `LPIRQ_IDX_STATUS) ? rd_status_v :
		(idx == `LPIRQ_IDX_CHECK) ? rd_check_v :
		(idx == `LPIRQ_IDX_OPTION) ? rd_option_v :
		(idx == `LPIRQ_IDX_BLUE) ? blue :
		(idx == `LPIRQ_IDX_REMOTE) ? rd_remote_v : 8'h00;

	// unmapped reads answer zero, unmapped writes are dropped
	always_ff @(posedge REF_CLK) begin
		if (RESET) begin
			ack <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else if (CLK_EN) begin
			ack <= req;
			if (rd)
				dat_o <= {24'h00_0000, rd_byte};
		end
	end

	assign WB_ACK_O = ack;
	assign WB_DAT_O = dat_o;

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RESET || !CLK_EN);

	sequence s_check_go;
		chk_start;
	endsequence
	sequence s_check_end;
		chk_state == lpirq_pkg::CHK_WAIT && HASH_DONE;
	endsequence
	sequence s_reset_write;
		wr_remote && wd[`LPIRQ_B_RM_RESET];
	endsequence

	a_irq_gate: assert property (INT_OUT |-> enable[0])
		else $error("interrupt out without global enable");
	a_irq_source: assert property (ev[1] && enable[1] && enable[0] && !wr_enable
		|=> INT_OUT && rd_status_v[0])
		else $error("enabled flag did not raise interrupt");
	a_done_flags: assert property (REMOTE_DONE |=> status[7] && rm_done)
		else $error("remote completion not flagged");
	a_found_wait: assert property (needs_lock && !SINK_LOCKED && !status[6]
		&& !ev[6] |=> !status[6])
		else $error("sink found flagged before lock");
	a_down_req: assert property (req_n_q && !DOWNSTREAM_REQUEST_N |=> status[5])
		else $error("downstream request not flagged");
	a_key_ready: assert property (KEY_LIST_READY || SINK_KEY_READY
		|=> status[4] || status[3])
		else $error("key ready not flagged");
	a_hs_flags: assert property (HANDSHAKE_FAIL |=> status[2])
		else $error("handshake failure not flagged");
	a_check_run: assert property (s_check_go |=> HASH_START && chk_go && !chk_fin
		##2 HASH_WORD_VALID)
		else $error("key check did not start");
	a_check_end: assert property (s_check_end |=> !chk_go && chk_fin
		&& chk_ok == $past(digest_match))
		else $error("key check result wrong");
	a_blue_fill: assert property (BLUE_SUBSTITUTE && !wr_blue |=> BLUE_OUT == blue)
		else $error("blue fill value not driven");
	a_master_reset: assert property (s_reset_write |=> REMOTE_MASTER_RESET
		##1 idle_cnt == 32'h0000_0000)
		else $error("remote master reset not issued");
	a_timeout_off: assert property (rm_off |-> !REMOTE_IDLE_TIMEOUT)
		else $error("timeout while disabled");
	a_timeout_short: assert property (rm_short && !rm_off && !wr_remote
		&& !REMOTE_BUS_ACTIVE && !rm_reset && idle_cnt == IDLE_SHORT_CYC
		|=> REMOTE_IDLE_TIMEOUT)
		else $error("short idle timeout missed");
	a_nack_clear: assert property (REMOTE_DONE && !REMOTE_TARGET_ACKED
		|=> !rm_acked)
		else $error("acknowledge flag set on failure");
	a_done_read: assert property (rd_remote && !REMOTE_DONE |=> !rm_done)
		else $error("done not cleared by read");
	a_flag_sticky: assert property (status[3] && !(wr_status && wd[3])
		|=> status[3][*1])
		else $error("event flag lost");
	a_pass_flag: assert property (HANDSHAKE_PASS |=> status[1])
		else $error("handshake pass not flagged");
	a_fast_follow: assert property (wr_remote
		|=> REMOTE_FAST_MODE == $past(wd[`LPIRQ_B_RM_FAST]))
		else $error("fast mode bit not applied");
	a_start_clear: assert property (REMOTE_START && !REMOTE_DONE
		|=> !rm_done && !rm_acked)
		else $error("new access did not clear done");

endmodule: lpirq_regs

//--- verif/lpirq_far_model.sv
// far-side model: key store with synchronous read and a stand-in hasher
`timescale 1ns/100ps
module lpirq_far_model (
	input wire logic clk, // core clock
	input wire logic corrupt, // spoil one key word
	input wire logic slow, // late digest
	input wire logic [5:0] key_addr, // key address
	output logic [31:0] key_data, // key word
	input wire logic hash_start, // new digest
	input wire logic [31:0] hash_word, // word in
	input wire logic hash_word_valid, // word strobe
	output logic hash_done, // digest ready
	output logic [159:0] hash_digest // count and xor of words
);
	logic [31:0] acc;
	logic [31:0] cnt;
	int wait_n;
	// ***************
	// key store and hasher
	// ***************
	// not a real hash: count and xor still expose lost, doubled or wrong words
	always_ff @(posedge clk) begin
		key_data <= {26'h0, key_addr} * 32'h3 + 32'h1 + {31'h0, corrupt && key_addr == 6'h05};
		hash_done <= 1'b0;
		if (hash_start) begin
			acc <= 32'h0;
			cnt <= 32'h0;
			wait_n <= slow ? 20 : 1;
		end else if (hash_word_valid) begin
			acc <= acc ^ hash_word;
			cnt <= cnt + 32'h1;
		end else if (cnt == 32'h28 && wait_n > 0) begin
			wait_n <= wait_n - 1;
			hash_done <= (wait_n == 1);
		end
	end
	assign hash_digest = {cnt, acc, 96'h0};
endmodule: lpirq_far_model

//--- verif/tb.sv
// self-checking bench for the protection register bank
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
	$display("Error %0t: got %h expected %h", $time, (a), (b)); end end
module tb;
	logic clk, rst, we, cyc, stb, ack, int_o, rstart, acked, bus_act, lock, blue_sub;
	logic rm_rst, fast, tmo, hstart, hvalid, hdone, corrupt, slow, en;
	logic [3:0] sel;
	logic [9:0] adr;
	logic [31:0] dat, q, kdata, hword, x;
	logic [7:0] evs, video, blue_out, r;
	logic [5:0] kaddr;
	logic [159:0] hdig, stored;
	int tests_run, bad_count, rm_cnt;
	lpirq_regs #(.IDLE_LONG_CYC(40), .IDLE_SHORT_CYC(10)) i_lpirq_regs (.REF_CLK(clk),
		.RESET(rst), .CLK_EN(en), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(q),
		.WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
		.INT_OUT(int_o), .HANDSHAKE_PASS(evs[1]), .HANDSHAKE_FAIL(evs[2]),
		.SINK_KEY_READY(evs[3]), .KEY_LIST_READY(evs[4]), .DOWNSTREAM_REQUEST_N(~evs[5]),
		.SINK_FOUND(evs[6]), .SINK_LOCKED(lock), .REMOTE_START(rstart), .REMOTE_DONE(evs[7]),
		.REMOTE_TARGET_ACKED(acked), .REMOTE_BUS_ACTIVE(bus_act), .REMOTE_MASTER_RESET(rm_rst),
		.REMOTE_FAST_MODE(fast), .REMOTE_IDLE_TIMEOUT(tmo), .KEY_ADDR(kaddr), .KEY_DATA(kdata),
		.HASH_START(hstart), .HASH_WORD(hword), .HASH_WORD_VALID(hvalid), .HASH_DONE(hdone),
		.HASH_DIGEST(hdig), .STORED_DIGEST(stored), .BLUE_SUBSTITUTE(blue_sub),
		.VIDEO_BLUE(video), .BLUE_OUT(blue_out));
	lpirq_far_model i_lpirq_far_model (.clk(clk), .corrupt(corrupt), .slow(slow),
		.key_addr(kaddr), .key_data(kdata), .hash_start(hstart), .hash_word(hword),
		.hash_word_valid(hvalid), .hash_done(hdone), .hash_digest(hdig));
	// ***************
	// clock, bus and helpers
	// ***************
	always #5 clk = ~clk;
	always @(posedge clk) if (rm_rst === 1'b1) rm_cnt++;
	task wb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] rv);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat <= {24'h0, d};
		n = 0;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
		`CHK(ack, 1'b1)
		rv = q[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask: wb
	task wr(input logic [7:0] i, input logic [7:0] d);
		wb(1'b1, i, d, r);
	endtask: wr
	task rc(input logic [7:0] i, input logic [7:0] e);
		wb(1'b0, i, 8'h00, r);
		`CHK(r, e)
	endtask: rc
	task ev(input int b);
		@(posedge clk);
		evs[b] <= 1'b1;
		@(posedge clk);
		evs[b] <= 1'b0;
	endtask: ev
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask: tally_and_finish
	// ***************
	// scenarios
	// ***************
	task t_reset_blue;
		rc(8'hC6, 8'h00);
		rc(8'hC7, 8'h00);
		rc(8'hC8, 8'h00);
		wr(8'hC8, 8'h23);
		rc(8'hC8, 8'h23);
		rc(8'hD0, 8'h00);
		wr(8'h10, 8'hAA);
		rc(8'h10, 8'h00);
		rc(8'hCE, 8'hFF);
		`CHK(blue_out, 8'hFF)
		wr(8'hCE, 8'h5A);
		@(posedge clk);
		`CHK(blue_out, 8'h5A)
		sel <= 4'hE;
		wr(8'hCE, 8'h00);
		sel <= 4'hF;
		rc(8'hCE, 8'h5A);
		blue_sub <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(blue_out, 8'h12)
	endtask: t_reset_blue
	task t_events;
		wr(8'hC6, 8'hFE);
		for (int i = 1; i < 8; i++) begin
			ev(i);
			rc(8'hC7, 8'((2 << i) - 1));
			`CHK(int_o, 1'b0)
		end
		wr(8'hC6, 8'hFF);
		`CHK(int_o, 1'b1)
		wr(8'hC6, 8'h01);
		rc(8'hC7, 8'hFE);
		`CHK(int_o, 1'b0)
		wr(8'hC7, 8'hFE);
		rc(8'hC7, 8'h00);
		wr(8'hCA, 8'h01);
		evs[6] <= 1'b1;
		rc(8'hC7, 8'h00);
		lock <= 1'b1;
		rc(8'hC7, 8'h40);
		evs[6] <= 1'b0;
		wr(8'hC7, 8'h40);
		wr(8'hCA, 8'h00);
		en <= 1'b0;
		ev(1);
		en <= 1'b1;
		rc(8'hC7, 8'h00);
	endtask: t_events
	task t_remote;
		int n;
		rc(8'hD0, 8'h01);
		acked <= 1'b1;
		ev(7);
		rc(8'hD0, 8'h03);
		rc(8'hD0, 8'h02);
		ev(7);
		rstart <= 1'b1;
		@(posedge clk);
		rstart <= 1'b0;
		acked <= 1'b0;
		rc(8'hD0, 8'h00);
		ev(7);
		rc(8'hC7, 8'h80);
		rc(8'hD0, 8'h01);
		wr(8'hC7, 8'h80);
		wr(8'hD0, 8'h10);
		`CHK(fast, 1'b1)
		wr(8'hD0, 8'h00);
		`CHK(fast, 1'b0)
		n = rm_cnt;
		wr(8'hD0, 8'h80);
		repeat (2) @(posedge clk);
		`CHK(rm_cnt, n + 1)
		rc(8'hD0, 8'h00);
	endtask: t_remote
	task t_idle;
		bus_act <= 1'b1;
		wr(8'hD0, 8'h40);
		bus_act <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK(tmo, 1'b0)
		repeat (10) @(posedge clk);
		`CHK(tmo, 1'b1)
		wr(8'hD0, 8'h00);
		`CHK(tmo, 1'b0)
		repeat (30) @(posedge clk);
		`CHK(tmo, 1'b1)
		wr(8'hD0, 8'h20);
		`CHK(tmo, 1'b0)
	endtask: t_idle
	task t_check(input logic bad, input logic [7:0] e);
		int n;
		corrupt <= bad;
		slow <= bad;
		wr(8'hC8, 8'h04);
		rc(8'hC8, 8'h04);
		n = 0;
		do begin wb(1'b0, 8'hC8, 8'h00, r); n++; end while (r[6] !== 1'b1 && n < 60);
		`CHK(r, e)
	endtask: t_check
	initial begin
		{clk, we, cyc, stb, evs, rstart, acked, bus_act, lock, corrupt, slow} = '0;
		{tests_run, bad_count, rm_cnt} = '0;
		sel = 4'hF;
		en = 1'b1;
		adr = 10'h000;
		dat = 32'h0;
		blue_sub = 1'b1;
		video = 8'h12;
		x = 32'h0;
		for (int i = 0; i < 40; i++) x = x ^ (i * 3 + 1);
		stored = {32'h28, x, 96'h0};
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset_blue();
		t_events();
		t_remote();
		t_idle();
		t_check(1'b0, 8'hC0);
		t_check(1'b1, 8'h40);
		tally_and_finish();
	end
	initial begin
		#100000;
		bad_count++;
		tally_and_finish();
	end
endmodule: tb
